// *** hdl/ddc_pkg.sv ***
// package of the drum/disc port
// Behaviour
// - input character lines are low-true, inverted on capture
// - sixth input line lands in word bit zero
// - halt line low ends the transfer
// - low skip line makes processor skip next
// - buffer-mode energize instruction gives buffer pulse
// - io-mode energize instruction gives io pulse
// - interlace output high while interlace runs
// - error line low is an error condition
// - halt interlock shows characters are being processed
// - pending flop marks due register transfer, exported
// - strobe seen flop set on strobe, exported
// - cycle window true from T6 to T3
// - direction bit: high output, low input
// - other unit address bits drive select outputs
// - output characters: sixth line lsb, odd parity
package ddc_pkg;
  // character and word shape
  localparam int CHAR_W         = 6;
  localparam int CHARS_PER_WORD = 4;
  localparam int UNIT_SEL_W     = 5;
  localparam int ADDR_W         = 5;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_UNIT  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_INSTR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_RXW   = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_TXW   = 5'h10;
  // unit register fields
  localparam int UNIT_DIR_BIT = 0;
  localparam int UNIT_SEL_LSB = 1;
  localparam logic [UNIT_SEL_W:0] UNIT_RST = 6'h00;
  // instruction register fields
  localparam int INSTR_MODE_BIT  = 0;
  localparam int INSTR_START_BIT = 1;
  localparam int INSTR_STOP_BIT  = 2;
  // status register fields
  localparam int SB_ACTIVE  = 0;
  localparam int SB_HALTED  = 1;
  localparam int SB_ERROR   = 2;
  localparam int SB_PARERR  = 3;
  localparam int SB_SKIP    = 4;
  localparam int SB_RXRDY   = 5;
  localparam int SB_TXEMPTY = 6;
  localparam int SB_ERRLINE = 7;
  localparam int STAT_W     = 8;
  // cycle timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PHASE_NS      = 250;
  localparam int PHASE_CYC     = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PHASES    = 4'h8;
  localparam logic [3:0] WIN_FIRST = 4'h6;
  localparam logic [3:0] WIN_LAST  = 4'h3;
  // link inputs as they arrive at the pins
  typedef struct packed {
    logic [CHAR_W-1:0] char_n;
    logic              parity_n;
    logic              strobe;
    logic              halt_n;
    logic              error_n;
    logic              skip_n;
  } ddc_link_in_t;
  // outgoing character with its parity
  typedef struct packed {
    logic [CHAR_W-1:0] data;
    logic              parity;
  } ddc_char_t;
  // transfer sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN  = 3'b010,
    S_MOVE = 3'b100
  } ddc_state_t;
  // parity bit that makes the character plus parity odd
  function automatic logic odd_par(input logic [CHAR_W-1:0] c);
    return ~^c;
  endfunction : odd_par
endpackage : ddc_pkg

// *** hdl/ddc_port.sv ***
// channel side of the drum/disc port
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module ddc_port #(
  parameter int CHARS_P     = ddc_pkg::CHARS_PER_WORD,
  parameter int PHASE_CYC_P = ddc_pkg::PHASE_CYC
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // avalon-mm slave
  input  wire logic [ddc_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  // link from the storage unit
  input  wire ddc_pkg::ddc_link_in_t         link_in,
  // character out to the unit
  output ddc_pkg::ddc_char_t                 out_char,
  // unit address lines
  output logic                               dir_is_output,
  output logic                               unit_sel_a,
  output logic                               unit_sel_b,
  output logic      [2:0]                    unit_sel_rest,
  // instruction pulses
  output logic                               buf_ctl_pulse,
  output logic                               io_ctl_pulse,
  // interlock and timing flops
  output logic                               interlace_active,
  output logic                               halt_interlock,
  output logic                               xfer_pending_flop,
  output logic                               strobe_seen_flop,
  output logic                               cycle_window
);
  import ddc_pkg::*;

  localparam int WW = CHARS_P * CHAR_W;  // assembled word width

  // refuse word shapes the 32-bit bus cannot carry
  if (CHARS_P < 1 || CHARS_P > 32 / CHAR_W)
  begin : g_bad_chars
    $error("chars per word out of range");
  end
  if (PHASE_CYC_P < 1 || PHASE_CYC_P > 65535)
  begin : g_bad_phase
    $error("phase length out of range");
  end

  // register address match
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] o);
    return a == o;
  endfunction : hit

  // synchroniser and edge state
  ddc_link_in_t      sync1_ff;     // first stage
  ddc_link_in_t      sync2_ff;     // settled link levels
  logic              strobe_d_ff;  // strobe one clock earlier
  // bus slave state
  logic              wait_ff;      // waitrequest
  logic [31:0]       rdata_ff;     // read data
  // software registers
  logic [UNIT_SEL_W:0] unit_ff;    // direction plus select bits
  logic [WW-1:0]     tx_word_ff;   // word to send
  logic              tx_full_ff;   // fresh tx word
  logic [WW-1:0]     rx_word_ff;   // last completed input word
  logic              rx_rdy_ff;    // rx_word not yet read
  // sequencer
  ddc_state_t        state_ff;
  logic [2:0]        cnt_ff;       // characters done in this word
  logic [WW-1:0]     asm_ff;       // input word assembly
  logic [WW-1:0]     tx_sh_ff;     // output word being sent
  ddc_char_t         out_char_ff;
  // flags
  logic              pend_ff;
  logic              seen_ff;
  logic              ilace_ff;
  logic              hilk_ff;
  logic              halted_ff;
  logic              err_ff;
  logic              parerr_ff;
  logic              buc_ff;
  logic              ioc_ff;
  // cycle timing
  logic [15:0]       div_ff;
  logic [3:0]        phase_ff;     // T1..T8
  logic              win_ff;

  // decoded link levels
  logic              strobe_rise;
  logic              halt_seen;
  logic [CHAR_W-1:0] rx_char;
  logic              rx_par;
  // decoded bus and sequencer events
  logic              wr_go;
  logic              rd_go;
  logic              start_req;
  logic              stop_req;
  logic              out_mode;
  logic              take;
  logic              last;
  logic              end_req;
  logic              move_done;
  logic              load_tx;
  logic [STAT_W-1:0] stat_v;

  // link inputs pass two flops before any use
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_ff    <= '1;
      sync2_ff    <= '1;
      strobe_d_ff <= 1'b1;
    end
    else
    begin
      sync1_ff    <= link_in;
      sync2_ff    <= sync1_ff;
      strobe_d_ff <= sync2_ff.strobe;
    end
  end

  // inversion restores true data
  assign strobe_rise = sync2_ff.strobe & ~strobe_d_ff;
  assign halt_seen   = ~sync2_ff.halt_n;
  assign rx_char     = ~sync2_ff.char_n;
  assign rx_par      = ~sync2_ff.parity_n;

  // a request completes where waitrequest is low
  assign wr_go = avs_write & ~wait_ff;
  assign rd_go = avs_read & ~wait_ff;
  assign start_req = wr_go & hit(avs_address, OFS_INSTR)
                     & avs_writedata[INSTR_START_BIT];
  assign stop_req  = wr_go & hit(avs_address, OFS_INSTR)
                     & avs_writedata[INSTR_STOP_BIT];

  // sequencer events
  assign out_mode  = unit_ff[UNIT_DIR_BIT];
  // a strobe during halt is dropped; the halt wins
  assign take      = (state_ff == S_RUN) & strobe_rise & ~halt_seen;
  assign last      = cnt_ff == 3'(CHARS_P - 1);
  assign end_req   = (state_ff != S_IDLE) & (halt_seen | stop_req);
  // the move waits for software rather than overrun a word
  assign move_done = (state_ff == S_MOVE)
                     & (out_mode ? tx_full_ff : ~rx_rdy_ff);
  assign load_tx   = move_done & out_mode;

  // status word for software
  always_comb
  begin
    stat_v             = '0;
    stat_v[SB_ACTIVE]  = ilace_ff;
    stat_v[SB_HALTED]  = halted_ff;
    stat_v[SB_ERROR]   = err_ff;
    stat_v[SB_PARERR]  = parerr_ff;
    stat_v[SB_SKIP]    = ~sync2_ff.skip_n;
    stat_v[SB_RXRDY]   = rx_rdy_ff;
    stat_v[SB_TXEMPTY] = ~tx_full_ff;
    stat_v[SB_ERRLINE] = ~sync2_ff.error_n;
  end

  // waitrequest drops for one cycle after each request
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wait_ff <= 1'b1;
    else if ((avs_read | avs_write) & wait_ff)
      wait_ff <= 1'b0;
    else
      wait_ff <= 1'b1;
  end

  // read data captured in the wait cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata_ff <= 32'h0;
    else if (avs_read & wait_ff)
    begin
      unique case (1'b1)
        hit(avs_address, OFS_UNIT): rdata_ff <= 32'(unit_ff);
        hit(avs_address, OFS_STAT): rdata_ff <= 32'(stat_v);
        hit(avs_address, OFS_RXW):  rdata_ff <= 32'(rx_word_ff);
        hit(avs_address, OFS_TXW):  rdata_ff <= 32'(tx_word_ff);
        default:                    rdata_ff <= 32'h0;  // unmapped, instr
      endcase
    end
  end

  // unit address register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      unit_ff <= UNIT_RST;
    else if (wr_go & hit(avs_address, OFS_UNIT))
      unit_ff <= avs_writedata[UNIT_SEL_W:0];
  end

  // energize instruction pulses, one clock each
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      buc_ff <= 1'b0;
      ioc_ff <= 1'b0;
    end
    else
    begin
      buc_ff <= wr_go & hit(avs_address, OFS_INSTR)
                & ~avs_writedata[INSTR_MODE_BIT];
      ioc_ff <= wr_go & hit(avs_address, OFS_INSTR)
                & avs_writedata[INSTR_MODE_BIT];
    end
  end

  // sequencer: idle, run characters, move a word
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_ff <= S_IDLE;
      cnt_ff   <= 3'h0;
    end
    else if (end_req)
      state_ff <= S_IDLE;
    else
    begin
      unique case (state_ff)
        S_IDLE:
        begin
          cnt_ff <= 3'h0;
          // output fetches a word first
          if (start_req)
            state_ff <= out_mode ? S_MOVE : S_RUN;
        end
        S_RUN:
        begin
          if (take & last)
          begin
            state_ff <= S_MOVE;
            cnt_ff   <= 3'h0;
          end
          else if (take)
            cnt_ff <= cnt_ff + 3'h1;
        end
        S_MOVE:
        begin
          if (move_done)
            state_ff <= S_RUN;
        end
        default:
          state_ff <= S_IDLE;  // illegal code recovers
      endcase
    end
  end

  // transfer pending while a word move is due
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pend_ff <= 1'b0;
    else if (end_req | move_done)
      pend_ff <= 1'b0;
    else if ((take & last) | (start_req & out_mode
             & (state_ff == S_IDLE)))
      pend_ff <= 1'b1;
  end

  // strobe seen, one clock per strobe; pending alone then gates the unit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      seen_ff <= 1'b0;
    else if (take)
      seen_ff <= 1'b1;
    else
      seen_ff <= 1'b0;
  end

  // input assembly, first character ends high
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      asm_ff <= '0;
    else if (take & ~out_mode)
      asm_ff <= (asm_ff << CHAR_W) | WW'(rx_char);
  end

  // odd parity check on every input character
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      parerr_ff <= 1'b0;
    else if (take & ~out_mode & ~(^{rx_char, rx_par}))
      parerr_ff <= 1'b1;
    else if (wr_go & hit(avs_address, OFS_STAT)
             & avs_writedata[SB_PARERR])
      parerr_ff <= 1'b0;
  end

  // completed input word; a new word beats a read clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_word_ff <= '0;
      rx_rdy_ff  <= 1'b0;
    end
    else if (move_done & ~out_mode)
    begin
      rx_word_ff <= asm_ff;
      rx_rdy_ff  <= 1'b1;
    end
    else if (rd_go & hit(avs_address, OFS_RXW))
      rx_rdy_ff <= 1'b0;
  end

  // output word register; a write beats the load clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_word_ff <= '0;
      tx_full_ff <= 1'b0;
    end
    else if (wr_go & hit(avs_address, OFS_TXW))
    begin
      tx_word_ff <= avs_writedata[WW-1:0];
      tx_full_ff <= 1'b1;
    end
    else if (load_tx)
      tx_full_ff <= 1'b0;
  end

  // output shifter: one character per strobe, high end first
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_sh_ff    <= '0;
      out_char_ff <= '0;
    end
    else if (load_tx)
      tx_sh_ff <= tx_word_ff;
    else if (take & out_mode)
    begin
      out_char_ff.data   <= tx_sh_ff[WW-1 -: CHAR_W];
      out_char_ff.parity <= odd_par(tx_sh_ff[WW-1 -: CHAR_W]);
      tx_sh_ff           <= tx_sh_ff << CHAR_W;
    end
  end

  // interlace active from start to end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ilace_ff <= 1'b0;
    else if (end_req)
      ilace_ff <= 1'b0;
    else if (start_req & (state_ff == S_IDLE))
      ilace_ff <= 1'b1;
  end

  // halt interlock: set once characters flow
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      hilk_ff <= 1'b0;
    else if (start_req & (state_ff == S_IDLE))
      hilk_ff <= 1'b0;
    else if (take)
      hilk_ff <= 1'b1;
  end

  // sticky halt and error flags; events beat clears
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      halted_ff <= 1'b0;
      err_ff    <= 1'b0;
    end
    else
    begin
      if (halt_seen & (state_ff != S_IDLE))
        halted_ff <= 1'b1;
      else if (wr_go & hit(avs_address, OFS_STAT)
               & avs_writedata[SB_HALTED])
        halted_ff <= 1'b0;
      if (~sync2_ff.error_n)
        err_ff <= 1'b1;
      else if (wr_go & hit(avs_address, OFS_STAT)
               & avs_writedata[SB_ERROR])
        err_ff <= 1'b0;
    end
  end

  // phase divider; window true in T6,T7,T8,T1,T2,T3
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      div_ff   <= 16'h0;
      phase_ff <= 4'h1;
      win_ff   <= 1'b1;
    end
    else if (div_ff == 16'(PHASE_CYC_P - 1))
    begin
      div_ff <= 16'h0;
      if (phase_ff == PHASES)
      begin
        phase_ff <= 4'h1;
        win_ff   <= 1'b1;
      end
      else
      begin
        phase_ff <= phase_ff + 4'h1;
        win_ff   <= (phase_ff + 4'h1 >= WIN_FIRST)
                    | (phase_ff + 4'h1 <= WIN_LAST);
      end
    end
    else
      div_ff <= div_ff + 16'h1;
  end

  // outputs straight from flops
  assign avs_readdata      = rdata_ff;
  assign avs_waitrequest   = wait_ff;
  assign out_char          = out_char_ff;
  assign dir_is_output     = unit_ff[UNIT_DIR_BIT];
  assign unit_sel_a        = unit_ff[UNIT_SEL_LSB];
  assign unit_sel_b        = unit_ff[UNIT_SEL_LSB + 1];
  assign unit_sel_rest     = unit_ff[UNIT_SEL_W -: 3];
  assign buf_ctl_pulse     = buc_ff;
  assign io_ctl_pulse      = ioc_ff;
  assign interlace_active  = ilace_ff;
  assign halt_interlock    = hilk_ff;   // status only, not watched by the unit
  assign xfer_pending_flop = pend_ff;   // gate source
  assign strobe_seen_flop  = seen_ff;
  assign cycle_window      = win_ff;
endmodule : ddc_port

// *** dv/ddc_port_asserts.sv ***
// checker of the drum/disc port
`timescale 1ns/1ns
module ddc_port_asserts #(
  parameter int PHASE_CYC_P = 1
) (
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       rst,
  // avalon-mm slave
  input wire logic [ddc_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  // link both ways
  input wire ddc_pkg::ddc_link_in_t      link_in,
  input wire ddc_pkg::ddc_char_t         out_char,
  // unit address lines
  input wire logic                       dir_is_output,
  input wire logic                       unit_sel_a,
  input wire logic                       unit_sel_b,
  input wire logic [2:0]                 unit_sel_rest,
  // pulses and flops
  input wire logic                       buf_ctl_pulse,
  input wire logic                       io_ctl_pulse,
  input wire logic                       interlace_active,
  input wire logic                       halt_interlock,
  input wire logic                       xfer_pending_flop,
  input wire logic                       strobe_seen_flop,
  input wire logic                       cycle_window
);
  import ddc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  int   lo_cnt;  // low window run length
  int   hi_cnt;  // high window run length
  logic lo_seen; // first high run is short, skipped
  // run lengths of the cycle window
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lo_cnt  <= 0;
      hi_cnt  <= 0;
      lo_seen <= 1'b0;
    end
    else
    begin
      lo_cnt <= cycle_window ? 0 : lo_cnt + 1;
      hi_cnt <= cycle_window ? hi_cnt + 1 : 0;
      if (!cycle_window) lo_seen <= 1'b1;
    end
  end
  // accepted write to one register
  sequence s_acc(logic [ADDR_W-1:0] a);
    avs_write && !avs_waitrequest && avs_address == a;
  endsequence
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("bus answer late");
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer held too long");
  property p_unit; s_acc(OFS_UNIT) |=>
    {unit_sel_rest, unit_sel_b, unit_sel_a, dir_is_output} == $past(avs_writedata[5:0]);
  endproperty
  a_unit: assert property (p_unit) else $error("unit lines wrong");
  property p_buf; s_acc(OFS_INSTR) ##0 !avs_writedata[0] |=>
    buf_ctl_pulse && !io_ctl_pulse ##1 !buf_ctl_pulse; endproperty
  a_buf: assert property (p_buf) else $error("buffer pulse wrong");
  property p_io; s_acc(OFS_INSTR) ##0 avs_writedata[0] |=>
    io_ctl_pulse && !buf_ctl_pulse ##1 !io_ctl_pulse; endproperty
  a_io: assert property (p_io) else $error("io pulse wrong");
  property p_win_lo; $rose(cycle_window) |-> lo_cnt == 2 * PHASE_CYC_P; endproperty
  a_win_lo: assert property (p_win_lo) else $error("window low run wrong");
  property p_win_hi; $fell(cycle_window) && lo_seen |-> hi_cnt == 6 * PHASE_CYC_P; endproperty
  a_win_hi: assert property (p_win_hi) else $error("window high run wrong");
  property p_halt; interlace_active && !link_in.halt_n |-> ##[1:5] !interlace_active; endproperty
  a_halt: assert property (p_halt) else $error("halt not obeyed");
  property p_seen; $rose(strobe_seen_flop) |-> link_in.strobe && $past(link_in.strobe, 2);
  endproperty
  a_seen: assert property (p_seen) else $error("strobe seen without strobe");
  property p_par; $rose(strobe_seen_flop) && dir_is_output |-> ^out_char == 1'b1; endproperty
  a_par: assert property (p_par) else $error("output parity even");
  property p_ilk; $rose(halt_interlock) |-> $rose(strobe_seen_flop); endproperty
  a_ilk: assert property (p_ilk) else $error("interlock without character");
endmodule : ddc_port_asserts
bind ddc_port ddc_port_asserts #(.PHASE_CYC_P(PHASE_CYC_P)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .link_in(link_in), .out_char(out_char),
  .dir_is_output(dir_is_output), .unit_sel_a(unit_sel_a), .unit_sel_b(unit_sel_b),
  .unit_sel_rest(unit_sel_rest), .buf_ctl_pulse(buf_ctl_pulse), .io_ctl_pulse(io_ctl_pulse),
  .interlace_active(interlace_active), .halt_interlock(halt_interlock),
  .xfer_pending_flop(xfer_pending_flop), .strobe_seen_flop(strobe_seen_flop),
  .cycle_window(cycle_window)
);

// *** dv/ddc_unit_model.sv ***
// partner: storage unit model
`timescale 1ns/1ns
module ddc_unit_model (
  // clock
  input wire logic               clk_sys,
  // channel flop watched for interlocking
  input wire logic               xfer_pending_flop,
  // character sent by the channel
  input wire ddc_pkg::ddc_char_t out_char,
  // lines toward the channel
  output ddc_pkg::ddc_link_in_t  link_in
);
  import ddc_pkg::*;
  ddc_char_t got;  // last character taken from the channel
  // idle: strobe low, other lines released high
  initial link_in = {6'h3f, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  // no strobe or halt while a word move is due
  task automatic wait_free();
    int n;
    n = 0;
    while (xfer_pending_flop !== 1'b0 && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_free
  // one character: strobe low 4+gap cycles, high 4
  task automatic strobe_char(input logic [CHAR_W-1:0] c, input logic bad, input int gap);
    wait_free();
    link_in.char_n   <= ~c;
    link_in.parity_n <= ^c ^ bad;
    repeat (4 + gap) @(posedge clk_sys);
    link_in.strobe <= 1'b1;
    repeat (4) @(posedge clk_sys);
    got = out_char;
    link_in.strobe <= 1'b0;
    // released lines show the inverse
    link_in.char_n   <= c;
    link_in.parity_n <= ~(^c ^ bad);
    @(posedge clk_sys);
  endtask : strobe_char
  // halt the process
  task automatic halt();
    wait_free();
    link_in.halt_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    link_in.halt_n <= 1'b1;
    @(posedge clk_sys);
  endtask : halt
  // error and skip levels
  task automatic set_lines(input logic err_n, input logic skp_n);
    link_in.error_n <= err_n;
    link_in.skip_n  <= skp_n;
  endtask : set_lines
endmodule : ddc_unit_model

// *** dv/ddc_port_tb_top.sv ***
// testbench of the drum/disc port
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ddc_port_tb_top;
  import ddc_pkg::*;
  logic              clk_sys, rst, avs_read, avs_write, avs_waitrequest; // clock and bus
  logic [ADDR_W-1:0] avs_address;
  logic [31:0]       avs_writedata, avs_readdata, d;
  ddc_link_in_t      link_in;
  ddc_char_t         out_char;
  logic              dir_is_output, unit_sel_a, unit_sel_b, buf_ctl_pulse, io_ctl_pulse;
  logic              interlace_active, halt_interlock, xfer_pending_flop, strobe_seen_flop;
  logic              cycle_window, seen_q;
  logic [2:0]        unit_sel_rest;
  logic [5:0]        c;
  int                n_mismatch, compares, n_buf, n_io, n_seen, b0, i0;
  logic [5:0]        ci [8] = '{6'h2a, 6'h15, 6'h3f, 6'h01, 6'h00, 6'h3e, 6'h21, 6'h10};
  logic [5:0]        uv [3] = '{6'h3f, 6'h2a, 6'h15};
  logic [23:0]       tw [2] = '{24'h9b4ce1, 24'h5a0f33};
  // short phases keep the window check quick
  ddc_port #(.PHASE_CYC_P(1)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_in(link_in), .out_char(out_char),
    .dir_is_output(dir_is_output), .unit_sel_a(unit_sel_a), .unit_sel_b(unit_sel_b),
    .unit_sel_rest(unit_sel_rest), .buf_ctl_pulse(buf_ctl_pulse), .io_ctl_pulse(io_ctl_pulse),
    .interlace_active(interlace_active), .halt_interlock(halt_interlock),
    .xfer_pending_flop(xfer_pending_flop), .strobe_seen_flop(strobe_seen_flop),
    .cycle_window(cycle_window));
  ddc_unit_model u_unit (.clk_sys(clk_sys), .xfer_pending_flop(xfer_pending_flop),
    .out_char(out_char), .link_in(link_in));
  // 20 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // pulse and strobe-seen counters
  always @(posedge clk_sys)
  begin
    if (buf_ctl_pulse === 1'b1) n_buf++;
    if (io_ctl_pulse === 1'b1) n_io++;
    if (strobe_seen_flop === 1'b1 && seen_q !== 1'b1) n_seen++;
    seen_q = strobe_seen_flop;
  end
  // verdict and end of run
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  // one bus cycle, held until waitrequest is low
  task automatic bus_go(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic wr,
                        output logic [31:0] r);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= v;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 100) n_mismatch++;
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask : bus_go
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    logic [31:0] r;
    bus_go(a, v, 1'b1, r);
  endtask : bus_wr
  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    bus_go(a, 32'h0, 1'b0, v);
  endtask : bus_rd
  // a hang is cut short here
  initial
  begin
    #2000000;
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("wait", 1'b1, avs_waitrequest)
    `CHK("outs", 5'h00, {interlace_active, halt_interlock, xfer_pending_flop, dir_is_output,
                         strobe_seen_flop})
    foreach (uv[j])
    begin
      bus_wr(OFS_UNIT, 32'hffffffc0 | uv[j]);
      bus_rd(OFS_UNIT, d);
      `CHK("unit", {26'h0, uv[j]}, d)
      `CHK("pins", uv[j], {unit_sel_rest, unit_sel_b, unit_sel_a, dir_is_output})
    end
    bus_wr(5'h14, 32'h3f);
    bus_rd(5'h14, d);
    `CHK("unmapped", 32'h0, d)
    for (int m = 0; m < 2; m++)
    begin
      b0 = n_buf;
      i0 = n_io;
      bus_wr(OFS_INSTR, 32'(m));
      repeat (2) @(posedge clk_sys);
      `CHK("buf", int'(m == 0), n_buf - b0)
      `CHK("io", m, n_io - i0)
    end
    // input: two words, second waits for a read
    bus_wr(OFS_UNIT, 32'h0);
    bus_wr(OFS_INSTR, 32'h2);
    @(posedge clk_sys);
    `CHK("ilace", 1'b1, interlace_active)
    for (int k = 0; k < 8; k++)
    begin
      u_unit.strobe_char(ci[k], 1'b0, k);
      `CHK("ilock", 1'b1, halt_interlock)
      if (k == 3)
      begin
        bus_rd(OFS_STAT, d);
        `CHK("rdy", 1'b1, d[SB_RXRDY])
        `CHK("perr", 1'b0, d[SB_PARERR])
      end
    end
    `CHK("pend", 1'b1, xfer_pending_flop)
    bus_rd(OFS_RXW, d);
    `CHK("w1", {8'h0, ci[0], ci[1], ci[2], ci[3]}, d)
    bus_rd(OFS_STAT, d);
    `CHK("pend2", 1'b0, xfer_pending_flop)
    `CHK("rdy2", 1'b1, d[SB_RXRDY])
    bus_rd(OFS_RXW, d);
    `CHK("w2", {8'h0, ci[4], ci[5], ci[6], ci[7]}, d)
    `CHK("seen", 8, n_seen)
    u_unit.strobe_char(6'h07, 1'b1, 0);
    bus_rd(OFS_STAT, d);
    `CHK("perr1", 1'b1, d[SB_PARERR])
    u_unit.set_lines(1'b0, 1'b0);
    repeat (4) @(posedge clk_sys);
    bus_rd(OFS_STAT, d);
    `CHK("errs", 3'h7, {d[SB_ERRLINE], d[SB_ERROR], d[SB_SKIP]})
    u_unit.set_lines(1'b1, 1'b1);
    repeat (4) @(posedge clk_sys);
    bus_wr(OFS_STAT, 32'hc);
    bus_rd(OFS_STAT, d);
    `CHK("errs0", 4'h0, {d[SB_ERRLINE], d[SB_ERROR], d[SB_SKIP], d[SB_PARERR]})
    bus_wr(OFS_INSTR, 32'h4);
    @(posedge clk_sys);
    `CHK("stop", 1'b0, interlace_active)
    // output: a word, one more character, a halt
    bus_wr(OFS_UNIT, 32'h1);
    bus_wr(OFS_TXW, {8'h0, tw[0]});
    bus_wr(OFS_INSTR, 32'h2);
    for (int k = 0; k < 5; k++)
    begin
      if (k == 4) bus_wr(OFS_TXW, {8'h0, tw[1]});
      c = (k < 4) ? tw[0][23 - 6 * k -: 6] : tw[1][23:18];
      u_unit.strobe_char(6'h00, 1'b0, 0);
      `CHK("out", {c, ~^c}, u_unit.got)
      if (k == 3) `CHK("pend3", 1'b1, xfer_pending_flop)
      if (k == 3) `CHK("last", 1'b1, halt_interlock & ~strobe_seen_flop & xfer_pending_flop)
    end
    u_unit.halt();
    `CHK("halt", 1'b0, interlace_active)
    bus_rd(OFS_STAT, d);
    `CHK("halted", 1'b1, d[SB_HALTED])
    stop_test();
  end
endmodule : ddc_port_tb_top
